// File: design/ashp_port.sv
// What this block does
// R1: EOC output low from sampling end to done
// R2: EOC behaviour only in conversion mode 00
// R3: Interrupt mode: falling edge marks data ready
// R4: Interrupt cleared by select fall or frame-start rise
// R5: Interrupt fall tri-states serial output
// R6: Frame-start low at select fall: input disabled
// R7: Frame-start fall resets counter, enables input
// R8: Input disabled at 16 edges or select rise
// R9: Output tri-stated after sixteenth bit
// R10: Power down while pin low; restart on activity
// R11: Serial clock shifts input and clocks conversion
// R12: MSB first; first four bits form command
// R13: Host sends twelve data bits for writes
// R14: No frame sync: sample on rising edges
// R15: Frame sync: sample on falling edges
// R16: Output high impedance until first bit driven
// R17: No frame sync: output updates on rising edges
// R18: Frame sync: first bit after frame-start low
// R19: Result twelve bits then four zeros
// R20: Config read: contents in last twelve bits
// R21: Host pads unused trailing bits with zeros
// R22: Select fall resets counter, enables both directions
// R23: Sample-start rise begins a conversion
// R24: Config bit picks EOC or interrupt function
`timescale 1ns/10ps
`default_nettype none
module ashp_port
    import ashp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic fs_i,
    input wire logic sdi_i,
    input wire logic sample_start_n_i,
    input wire logic power_down_pin_n_i,
    input wire logic [ashp_pkg::DATA_BITS-1:0] result_i,
    input wire logic sample_end_i,
    input wire logic conv_done_i,
    output logic sdo_o,
    output logic sdo_oe_n_o,
    output logic eoc_int_n_o,
    output ashp_pkg::ashp_cmd_s cmd_o,
    output ashp_pkg::ashp_cfg_wr_s cfg_wr_o,
    output logic [ashp_pkg::DATA_BITS-1:0] config_o,
    output logic conv_clk_en_o,
    output logic conv_start_o,
    output logic power_down_o
);
    import ashp_pkg::*;

    logic [NPIN-1:0] s1_ff;
    logic [NPIN-1:0] s2_ff;
    logic [NPIN-1:0] s3_ff;
    logic [NPIN-1:0] lvl_ff;
    logic [NPIN-1:0] nxt_lvl;
    logic [NPIN-1:0] rise_w;
    logic [NPIN-1:0] fall_w;
    wire logic [NPIN-1:0] pin_w = {power_down_pin_n_i, sample_start_n_i,
        sdi_i, fs_i, cs_n_i, sclk_i};

    // A change only counts once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < NPIN; g++)
        begin : g_pin
            assign nxt_lvl[g] = (s2_ff[g] == s3_ff[g]) ? s3_ff[g] : lvl_ff[g];
            assign rise_w[g] = nxt_lvl[g] & ~lvl_ff[g];
            assign fall_w[g] = ~nxt_lvl[g] & lvl_ff[g];
        end
    endgenerate

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s1_ff <= PIN_RST;
            s2_ff <= PIN_RST;
            s3_ff <= PIN_RST;
            lvl_ff <= PIN_RST;
        end
        else
        begin
            s1_ff <= pin_w;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            lvl_ff <= nxt_lvl;
        end
    end

    ashp_frm_e st_ff;
    logic fsm_ff;
    logic rxen_ff;
    logic [4:0] rxcnt_ff;
    logic [WORD_BITS-1:0] rxsh_ff;
    logic [4:0] txcnt_ff;
    logic [WORD_BITS-1:0] word_ff;
    logic sdo_ff;
    logic oe_n_ff;
    logic pin_ff;
    logic [DATA_BITS-1:0] cfg_ff;
    ashp_cmd_s cmd_ff;
    ashp_cfg_wr_s cfgw_ff;
    logic cclk_ff;
    logic sample_start_n_ff;
    logic pd_ff;

    wire logic sclk_r = rise_w[PIN_SCLK];
    wire logic sclk_f = fall_w[PIN_SCLK];
    wire logic cs_f = fall_w[PIN_CS];
    wire logic cs_r = rise_w[PIN_CS];
    wire logic fs_f = fall_w[PIN_FS];
    wire logic fs_r = rise_w[PIN_FS];
    wire logic sdi_v = nxt_lvl[PIN_SDI];
    wire logic int_mode = cfg_ff[CFG_INT_BIT];
    wire logic [1:0] conv_mode = cfg_ff[CFG_MODE_LSB+1:CFG_MODE_LSB];

    // Frame starts: select fall with frame-start high, or frame-start fall
    wire logic fs_low_at_cs = cs_f & ~nxt_lvl[PIN_FS];
    wire logic spi_start = cs_f & nxt_lvl[PIN_FS];
    wire logic dsp_start = fs_f & (st_ff != ASHP_IDLE) & ~cs_f;
    wire logic start_w = spi_start | dsp_start;
    wire logic run_w = (st_ff == ASHP_RUN) & ~cs_r;
    wire logic edge_w = fsm_ff ? sclk_f : sclk_r; // R14 R15 R17 R18
    wire logic shift_w = run_w & rxen_ff & edge_w & ~start_w;
    wire logic upd_w = run_w & ~oe_n_ff & edge_w & ~start_w;
    wire logic cmd_now = shift_w & (rxcnt_ff == CNT_CMD);
    wire logic last_now = shift_w & (rxcnt_ff == CNT_LAST);
    wire logic [3:0] code_w = {rxsh_ff[2:0], sdi_v}; // R12
    wire logic rd_cfg_now = cmd_now & (code_w == CMD_RD_CFG);
    wire logic wr_cfg_now = last_now & (cmd_ff.code == CMD_WR_CFG);
    // Config contents take the last twelve positions of the word
    wire logic [WORD_BITS-1:0] wsel = rd_cfg_now ?
        {word_ff[WORD_BITS-1:DATA_BITS], cfg_ff} : word_ff; // R20
    wire logic [3:0] bit_idx = IDX_TOP - txcnt_ff[3:0];
    wire logic int_fall = int_mode & conv_done_i & pin_ff; // R3
    wire logic int_clr = cs_f | fs_r; // R4

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_ff <= ASHP_IDLE;
            fsm_ff <= 1'b0;
        end
        else if (cs_r)
        begin
            st_ff <= ASHP_IDLE;
        end
        else if (fs_low_at_cs)
        begin
            st_ff <= ASHP_WAIT_FS;
            fsm_ff <= 1'b1;
        end
        else if (start_w)
        begin
            st_ff <= ASHP_RUN;
            fsm_ff <= dsp_start;
        end
    end

    // Receive side; host pads unused bits with zeros
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rxen_ff <= 1'b0;
            rxcnt_ff <= 5'h00;
            rxsh_ff <= '0;
        end
        else if (cs_r | fs_low_at_cs)
        begin
            rxen_ff <= 1'b0; // R6 R8
        end
        else if (start_w)
        begin
            rxen_ff <= 1'b1; // R7 R22
            rxcnt_ff <= 5'h00;
        end
        else if (shift_w)
        begin
            rxsh_ff <= {rxsh_ff[WORD_BITS-2:0], sdi_v}; // R11 R21
            rxcnt_ff <= rxcnt_ff + 5'h01;
            if (rxcnt_ff == CNT_LAST)
            begin
                rxen_ff <= 1'b0; // R8
            end
        end
    end

    // Transmit side; the interrupt fall overrides any frame activity
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            oe_n_ff <= 1'b1;
            sdo_ff <= 1'b0;
            txcnt_ff <= 5'h00;
            word_ff <= '0;
        end
        else if (int_fall | cs_r | fs_low_at_cs)
        begin
            oe_n_ff <= 1'b1; // R5 R16
        end
        else if (spi_start | (dsp_start & st_ff == ASHP_WAIT_FS))
        begin
            word_ff <= {result_i, ZERO_TAIL}; // R19
            sdo_ff <= result_i[DATA_BITS-1];
            oe_n_ff <= 1'b0; // R16 R18 R22
            txcnt_ff <= 5'h00;
        end
        else if (upd_w)
        begin
            word_ff <= wsel;
            txcnt_ff <= txcnt_ff + 5'h01;
            if (txcnt_ff == CNT_LAST)
            begin
                oe_n_ff <= 1'b1; // R9
            end
            else
            begin
                sdo_ff <= wsel[bit_idx]; // R17 R18
            end
        end
    end

    // Command decode and config writes
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cmd_ff <= '0;
            cfgw_ff <= '0;
            cfg_ff <= CFG_RST;
        end
        else
        begin
            cmd_ff.valid <= cmd_now; // R12
            if (cmd_now)
            begin
                cmd_ff.code <= code_w;
            end
            cfgw_ff.valid <= wr_cfg_now; // R13
            if (wr_cfg_now)
            begin
                cfgw_ff.data <= {rxsh_ff[DATA_BITS-2:0], sdi_v};
                cfg_ff <= {rxsh_ff[DATA_BITS-2:0], sdi_v};
            end
        end
    end

    // Shared status pin; in interrupt mode a new event beats a clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_ff <= 1'b1;
        end
        else if (int_mode)
        begin
            if (conv_done_i)
            begin
                pin_ff <= 1'b0; // R3 R24
            end
            else if (int_clr)
            begin
                pin_ff <= 1'b1; // R4
            end
        end
        else if (conv_mode != MODE_EOC)
        begin
            pin_ff <= 1'b1; // R2
        end
        else if (sample_end_i)
        begin
            pin_ff <= 1'b0; // R1 R24
        end
        else if (conv_done_i)
        begin
            pin_ff <= 1'b1; // R1
        end
    end

    // Conversion clock enable, start pulse and power state
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cclk_ff <= 1'b0;
            sample_start_n_ff <= 1'b0;
            pd_ff <= 1'b0;
        end
        else
        begin
            cclk_ff <= sclk_r; // R11
            sample_start_n_ff <= rise_w[PIN_SS]; // R23
            if (!lvl_ff[PIN_PD])
            begin
                pd_ff <= 1'b1; // R10
            end
            else if (!lvl_ff[PIN_CS] || !lvl_ff[PIN_SS])
            begin
                pd_ff <= 1'b0; // R10
            end
        end
    end

    assign sdo_o = sdo_ff;
    assign sdo_oe_n_o = oe_n_ff;
    assign eoc_int_n_o = pin_ff;
    assign cmd_o = cmd_ff;
    assign cfg_wr_o = cfgw_ff;
    assign config_o = cfg_ff;
    assign conv_clk_en_o = cclk_ff;
    assign conv_start_o = sample_start_n_ff;
    assign power_down_o = pd_ff;
endmodule
`default_nettype wire

// File: shared/ashp_pkg.sv
`default_nettype none
package ashp_pkg;
    localparam int WORD_BITS = 16;
    localparam int CMD_BITS = 4;
    localparam int DATA_BITS = 12;
    localparam int NPIN = 6;
    localparam int PIN_SCLK = 0;
    localparam int PIN_CS = 1;
    localparam int PIN_FS = 2;
    localparam int PIN_SDI = 3;
    localparam int PIN_SS = 4;
    localparam int PIN_PD = 5;
    localparam logic [NPIN-1:0] PIN_RST = 6'h36;
    localparam logic [3:0] CMD_RD_CFG = 4'h9;
    localparam logic [3:0] CMD_WR_CFG = 4'ha;
    localparam logic [11:0] CFG_RST = 12'h000;
    localparam int CFG_INT_BIT = 0;
    localparam int CFG_MODE_LSB = 1;
    localparam logic [1:0] MODE_EOC = 2'h0;
    localparam logic [4:0] CNT_CMD = 5'h03;
    localparam logic [4:0] CNT_LAST = 5'h0f;
    localparam logic [3:0] IDX_TOP = 4'he;
    localparam logic [3:0] ZERO_TAIL = 4'h0;

    typedef enum logic [1:0] {ASHP_IDLE, ASHP_WAIT_FS, ASHP_RUN} ashp_frm_e;

    typedef struct packed {
        logic valid;
        logic [CMD_BITS-1:0] code;
    } ashp_cmd_s;

    typedef struct packed {
        logic valid;
        logic [DATA_BITS-1:0] data;
    } ashp_cfg_wr_s;
endpackage
`default_nettype wire

// File: testbench/ashp_port_props.sv
`timescale 1ns/10ps
`default_nettype none
module ashp_port_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic sample_start_n_i,
    input wire logic power_down_pin_n_i,
    input wire logic sample_end_i,
    input wire logic conv_done_i,
    input wire logic sdo_oe_n_o,
    input wire logic eoc_int_n_o,
    input wire ashp_pkg::ashp_cmd_s cmd_o,
    input wire ashp_pkg::ashp_cfg_wr_s cfg_wr_o,
    input wire logic [ashp_pkg::DATA_BITS-1:0] config_o,
    input wire logic conv_clk_en_o,
    input wire logic conv_start_o,
    input wire logic power_down_o
);
    import ashp_pkg::*;
    wire logic intm = config_o[CFG_INT_BIT];
    wire logic eoc00 = !intm && config_o[CFG_MODE_LSB+:2] == MODE_EOC;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // Allows for the pin synchroniser before the frame logic
    oe_idle_a: assert property (cs_n_i [*8] |-> sdo_oe_n_o)
        else $error("serial output driven while deselected");
    cmd_wr_a: assert property (cfg_wr_o.valid |-> cmd_o.code == CMD_WR_CFG)
        else $error("config write without write command");
    cfg_upd_a: assert property (cfg_wr_o.valid |-> ##[0:1] config_o == cfg_wr_o.data)
        else $error("config not taken from write");
    int_set_a: assert property (conv_done_i && intm |=> !eoc_int_n_o)
        else $error("interrupt not raised on done");
    eoc_low_a: assert property (sample_end_i && eoc00 |=> !eoc_int_n_o)
        else $error("end of conversion not low at sample end");
    eoc_done_a: assert property (conv_done_i && !sample_end_i && eoc00 |=> eoc_int_n_o)
        else $error("end of conversion not released");
    eoc_off_a: assert property (!intm && !eoc00 && $stable(config_o) |=> eoc_int_n_o)
        else $error("pin active outside mode 00");
    start_a: assert property ($rose(sample_start_n_i) |-> ##[2:7] conv_start_o)
        else $error("sample start did not begin conversion");
    pd_a: assert property (!power_down_pin_n_i [*6] |=> power_down_o)
        else $error("not powered down");
    sclk_a: assert property ($rose(sclk_i) |-> ##[2:7] conv_clk_en_o)
        else $error("serial clock edge not passed on");
endmodule
bind ashp_port ashp_port_props i_ashp_port_props (.*);
`default_nettype wire

// File: testbench/ashp_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module ashp_host_model (
    input wire logic sdo_i,
    input wire logic sdo_oe_n_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic fs_o,
    output logic sdi_o
);
    wire pin = sdo_oe_n_i ? 1'bz : sdo_i;
    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        fs_o = 1'b1;
        sdi_o = 1'b0;
    end
    // Input turns over on the inactive edge, output is read just before
    // the active edge; pre holds the enable before frame-start fall (forced high without frame sync) and after bit 16
    task automatic frame(input bit dsp, input logic [15:0] w,
                         output logic [15:0] got, output logic [1:0] pre);
        fs_o <= !dsp;
        #24 cs_n_o <= 1'b0;
        #48 pre[1] = sdo_oe_n_i | !dsp;
        if (dsp)
        begin
            fs_o <= 1'b1;
            #48 fs_o <= 1'b0;
            #48;
        end
        for (int k = 15; k >= 0; k--)
        begin
            sdi_o <= w[k];
            sclk_o <= dsp;
            #23 got[k] = pin;
            #1 sclk_o <= !dsp;
            #24;
        end
        sclk_o <= 1'b0;
        sdi_o <= !sdi_o;
        #48 pre[0] = sdo_oe_n_i;
        cs_n_o <= 1'b1;
        fs_o <= 1'b1;
        #96;
    endtask
endmodule
`default_nettype wire

// File: testbench/ashp_port_test.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) \
    begin \
        n_tests++; \
        if ((a) !== (b)) \
        begin \
            failures++; \
            $display("ERROR t=%0t got=%h exp=%h", $time, a, b); \
        end \
    end
module ashp_port_test;
    import ashp_pkg::*;
    logic clk = 1'b0, rst = 1'b1, ss_n = 1'b1, pd_n = 1'b1;
    logic s_end = 1'b0, c_done = 1'b0;
    logic [11:0] res = 12'h000, cfg_m = 12'h000, cfg;
    logic sclk, cs_n, fs, serial_in, serial_out, oe_n, eoc_n, c_start, pd;
    logic [15:0] got;
    logic [1:0] pre;
    logic [3:0] cnt;
    ashp_cmd_s cmd;
    ashp_cfg_wr_s cwr;
    int failures = 0, n_tests = 0;
    logic [15:0] wt [6] = '{16'ha000, 16'h9000, 16'ha006,
                            16'ha001, 16'h9000, 16'h3000};
    bit dt [6] = '{0, 1, 0, 0, 1, 0};
    always #2.5 clk = ~clk;
    ashp_port i_ashp_port (
        .clk_i(clk), .rst_i(rst), .sclk_i(sclk), .cs_n_i(cs_n), .fs_i(fs),
        .sdi_i(serial_in), .sample_start_n_i(ss_n), .power_down_pin_n_i(pd_n),
        .result_i(res), .sample_end_i(s_end), .conv_done_i(c_done),
        .sdo_o(serial_out), .sdo_oe_n_o(oe_n), .eoc_int_n_o(eoc_n), .cmd_o(cmd),
        .cfg_wr_o(cwr), .config_o(cfg), .conv_clk_en_o(),
        .conv_start_o(c_start), .power_down_o(pd));
    ashp_host_model i_ashp_host_model (
        .sdo_i(serial_out), .sdo_oe_n_i(oe_n), .sclk_o(sclk), .cs_n_o(cs_n),
        .fs_o(fs), .sdi_o(serial_in));
    task automatic settle;
        repeat (8) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic ev(input logic [11:0] c);
        @(posedge clk) s_end <= 1'b1;
        @(posedge clk) s_end <= 1'b0;
        @(negedge clk) `CHK(eoc_n, c[0] | (c[2:1] != MODE_EOC))
        @(posedge clk) c_done <= 1'b1;
        @(posedge clk) c_done <= 1'b0;
        @(negedge clk) `CHK(eoc_n, !c[0])
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        void'($urandom(66801));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            @(posedge clk) res <= 12'($urandom);
            i_ashp_host_model.frame(dt[i], wt[i], got, pre);
            if (wt[i][15:12] == CMD_RD_CFG)
                `CHK(got[11:0], cfg_m)
            else
                `CHK(got, {res, ZERO_TAIL})
            if (wt[i][15:12] == CMD_WR_CFG)
                cfg_m = wt[i][11:0];
            `CHK(cmd.code, wt[i][15:12])
            `CHK(cfg, cfg_m)
            `CHK({pre, eoc_n}, 3'b111)
            ev(cfg_m);
        end
        // Interrupt mode is left on; a done pulse mid-frame must cut output
        fork
            i_ashp_host_model.frame(1'b0, 16'h0000, got, pre);
            begin
                repeat (60) @(negedge clk);
                `CHK(oe_n, 1'b0)
                @(posedge clk) c_done <= 1'b1;
                @(posedge clk) c_done <= 1'b0;
                @(negedge clk) `CHK(oe_n, 1'b1)
            end
        join
        @(posedge clk) pd_n <= 1'b0;
        settle;
        @(posedge clk) pd_n <= 1'b1;
        settle;
        `CHK(pd, 1'b1)
        @(posedge clk) ss_n <= 1'b0;
        settle;
        `CHK(pd, 1'b0)
        @(posedge clk) ss_n <= 1'b1;
        cnt = 4'h0;
        repeat (10) @(negedge clk) cnt = cnt + c_start;
        `CHK(cnt, 4'h1)
        end_of_test;
    end
    // Whole run needs under 15 us
    initial
    begin
        #50000;
        failures++;
        end_of_test;
    end
endmodule
`default_nettype wire
